// [design/upm_pkg.sv]
// Shared constants and types for the USB path monitor
package upm_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int unsigned CLK_KHZ      = 125000;  // 125 MHz core clock
  localparam int unsigned T_INIT_MS    = 10;      // Dwell in INITIAL
  localparam int unsigned T_DETACH_MS  = 3;       // Dwell in DETACH
  localparam int unsigned T_SE0_MS     = 3;       // SE0 length for reset/suspend
  // Cycle counts, exact at this rate
  localparam int unsigned INIT_CYC     = T_INIT_MS * CLK_KHZ;
  localparam int unsigned DETACH_CYC   = T_DETACH_MS * CLK_KHZ;
  localparam int unsigned SE0_CYC      = T_SE0_MS * CLK_KHZ;
  localparam int unsigned TMR_W        = 21;      // Holds 1.25M cycles

  // ************************************************************
  // Monitor states, Gray coded along the normal path
  // ************************************************************
  typedef enum logic [2:0] {
    UPM_RESET      = 3'h0,
    UPM_INITIAL    = 3'h1,
    UPM_DISCONNECT = 3'h3,
    UPM_FULL_LOW   = 3'h2,
    UPM_HS         = 3'h6,
    UPM_DETACH     = 3'h7
  } upm_state_t;

  // ************************************************************
  // APB register map
  // ************************************************************
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;   // Control, read/write
  localparam logic [7:0]  OFS_STATUS   = 8'h04;   // Status, read only
  localparam logic [1:0]  CTRL_RST_VAL = 2'h0;
  localparam int unsigned CTRL_FORCE   = 0;       // Soft force-pass-through
  localparam int unsigned CTRL_DISC    = 1;       // Soft disconnect
  localparam int unsigned ST_STATE_LSB = 0;       // State code, 3 bits
  localparam int unsigned ST_SWITCH    = 4;
  localparam int unsigned ST_BC_ONLY   = 5;
  localparam int unsigned ST_RESYNC    = 6;
  localparam int unsigned ST_OSC       = 7;
  localparam int unsigned ST_CONN      = 8;
  localparam int unsigned ST_DET_STRAP = 9;
  localparam int unsigned ST_FORCE     = 10;

endpackage : upm_pkg

// [design/upm_timer.sv]
// Run-length cycle timer used for state dwell and SE0 length
`timescale 1ns/1ps
`default_nettype none
module upm_timer #(
  parameter int unsigned W = 21
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_run,    // Count while high, clear when low
  input  wire logic [W-1:0] i_limit,  // Cycles of run before done
  output logic              o_done    // High on the limit-th run cycle
);

  logic [W-1:0] cnt;  // Cycles of run seen so far

  // ************************************************************
  // Counter: clearing on a low run restarts it on every entry
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b || !i_run)
    begin
      cnt <= '0;
    end
    else if (cnt != i_limit)
    begin
      cnt <= cnt + W'(1);
    end
  end

  // Saturating compare, so a long run cannot wrap
  assign o_done = i_run && (cnt >= (i_limit - W'(1)));

endmodule : upm_timer
`default_nettype wire

// [design/upm_path_monitor.sv]
// Bus monitor state machine choosing pass-through switch or resync path
`timescale 1ns/1ps
`default_nettype none
module upm_path_monitor #(
  parameter int unsigned INIT_CYCLES   = upm_pkg::INIT_CYC,
  parameter int unsigned DETACH_CYCLES = upm_pkg::DETACH_CYC,
  parameter int unsigned SE0_CYCLES    = upm_pkg::SE0_CYC
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,       // Chip reset low
  input  wire logic                       i_conn_en,     // Connection enable
  input  wire logic                       i_detach_en,   // Detach-state strap
  input  wire logic                       i_force_passthrough,
  input  wire logic                       i_sof_rise,    // SOF level rise pulse
  input  wire logic                       i_se0,         // SE0 on the lines
  input  wire logic                       i_chirp_end,   // HS handshake done
  input  wire logic                       i_resume_end,  // HS resume done
  input  wire logic                       i_psel,
  input  wire logic                       i_penable,
  input  wire logic                       i_pwrite,
  input  wire logic [upm_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]                i_pwdata,
  output logic [31:0]                     o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  output logic                            o_switch_on,   // Ports joined
  output logic                            o_bc_only,     // Charging-only pass
  output logic                            o_resync_en,   // Resync path active
  output logic                            o_osc_en,      // Oscillator/PLL run
  output logic [2:0]                      o_state        // State code
);

  // ************************************************************
  // Declarations
  // ************************************************************
  upm_pkg::upm_state_t state;        // Registered monitor state
  upm_pkg::upm_state_t next_state;   // Combinational next state
  logic [1:0]          ctrl;         // Software control bits
  logic                conn_ok;      // Effective connection enable
  logic                force_eff;    // Strap or software force
  logic                dwell_run;    // Timed state occupied
  logic                dwell_done;   // Dwell time reached
  logic                se0_run;      // SE0 seen while in HS
  logic                se0_done;     // SE0 lasted the full time
  logic                setup;        // APB setup phase
  logic                hit_ctrl;     // Address decodes
  logic                hit_status;
  logic [31:0]         status;       // Status word
  logic [upm_pkg::TMR_W-1:0] dwell_limit;

  // Software disconnect acts like the pin going low
  assign conn_ok   = i_conn_en && !ctrl[upm_pkg::CTRL_DISC];
  assign force_eff = i_force_passthrough || ctrl[upm_pkg::CTRL_FORCE];

  // ************************************************************
  // Path decode functions
  // ************************************************************
  // Switch is open only in RESET, and in HS/DETACH unless forced
  function automatic logic dec_switch(input upm_pkg::upm_state_t s,
                                      input logic f);
    dec_switch = (s != upm_pkg::UPM_RESET) &&
                 (f || ((s != upm_pkg::UPM_HS) && (s != upm_pkg::UPM_DETACH)));
  endfunction : dec_switch

  // Resync runs only in HS and never under force
  function automatic logic dec_resync(input upm_pkg::upm_state_t s,
                                      input logic f);
    dec_resync = (s == upm_pkg::UPM_HS) && !f;
  endfunction : dec_resync

  // ************************************************************
  // Timers
  // ************************************************************
  // Shared dwell timer; INITIAL and DETACH never touch, so it clears
  assign dwell_run   = (state == upm_pkg::UPM_INITIAL) ||
                       (state == upm_pkg::UPM_DETACH);
  assign dwell_limit = (state == upm_pkg::UPM_INITIAL) ?
                       upm_pkg::TMR_W'(INIT_CYCLES) :
                       upm_pkg::TMR_W'(DETACH_CYCLES);

  upm_timer #(
    .W       (upm_pkg::TMR_W)
  ) u_dwell (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_run   (dwell_run),
    .i_limit (dwell_limit),
    .o_done  (dwell_done)
  );

  // SE0 must be continuous; any break restarts the count
  assign se0_run = (state == upm_pkg::UPM_HS) && i_se0;

  upm_timer #(
    .W       (upm_pkg::TMR_W)
  ) u_se0 (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_run   (se0_run),
    .i_limit (upm_pkg::TMR_W'(SE0_CYCLES)),
    .o_done  (se0_done)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      // Leave reset on the first clock after release
      upm_pkg::UPM_RESET:      next_state = upm_pkg::UPM_INITIAL;
      upm_pkg::UPM_INITIAL:
      begin
        if (dwell_done)
          next_state = upm_pkg::UPM_DISCONNECT;
      end
      // Level test, so an enable already high passes straight on
      upm_pkg::UPM_DISCONNECT:
      begin
        if (conn_ok)
          next_state = upm_pkg::UPM_FULL_LOW;
      end
      upm_pkg::UPM_FULL_LOW:
      begin
        if (!conn_ok)
          next_state = upm_pkg::UPM_DISCONNECT;
        else if (i_chirp_end || i_resume_end)
          next_state = upm_pkg::UPM_HS;
      end
      // Enable low wins, then long SE0, then the SOF level rise
      upm_pkg::UPM_HS:
      begin
        if (!conn_ok)
          next_state = upm_pkg::UPM_DISCONNECT;
        else if (se0_done)
          next_state = upm_pkg::UPM_FULL_LOW;
        else if (i_sof_rise && i_detach_en)
          next_state = upm_pkg::UPM_DETACH;
        else if (i_sof_rise)
          next_state = upm_pkg::UPM_FULL_LOW;
      end
      upm_pkg::UPM_DETACH:
      begin
        if (!conn_ok)
          next_state = upm_pkg::UPM_DISCONNECT;
        else if (dwell_done)
          next_state = upm_pkg::UPM_FULL_LOW;
      end
      // Two unused codes recover through reset sequencing
      default:                 next_state = upm_pkg::UPM_RESET;
    endcase
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      state <= upm_pkg::UPM_RESET;
    else
      state <= next_state;
  end

  // ************************************************************
  // Path outputs
  // ************************************************************
  // Flopped from the next state so they change with the state and
  // never glitch; HS passage outside HS is not guaranteed anyway
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      o_switch_on <= 1'b0;
      o_bc_only   <= 1'b0;
      o_resync_en <= 1'b0;
      o_osc_en    <= 1'b0;
    end
    else
    begin
      o_switch_on <= dec_switch(next_state, force_eff);
      o_bc_only   <= (next_state == upm_pkg::UPM_INITIAL);
      o_resync_en <= dec_resync(next_state, force_eff);
      o_osc_en    <= (next_state != upm_pkg::UPM_RESET);
    end
  end

  assign o_state = state;

  // ************************************************************
  // APB slave: zero wait states, read data flopped in setup
  // ************************************************************
  assign setup      = i_psel && !i_penable;
  assign hit_ctrl   = (i_paddr == upm_pkg::OFS_CTRL);
  assign hit_status = (i_paddr == upm_pkg::OFS_STATUS);
  assign o_pready   = 1'b1;

  // Status word, unused bits read zero
  always_comb
  begin
    status = 32'h0000_0000;
    status[upm_pkg::ST_STATE_LSB +: 3] = state;
    status[upm_pkg::ST_SWITCH]         = o_switch_on;
    status[upm_pkg::ST_BC_ONLY]        = o_bc_only;
    status[upm_pkg::ST_RESYNC]         = o_resync_en;
    status[upm_pkg::ST_OSC]            = o_osc_en;
    status[upm_pkg::ST_CONN]           = i_conn_en;
    status[upm_pkg::ST_DET_STRAP]      = i_detach_en;
    status[upm_pkg::ST_FORCE]          = i_force_passthrough;
  end

  // Control register, written only at the access edge
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      ctrl <= upm_pkg::CTRL_RST_VAL;
    else if (i_psel && i_penable && i_pwrite && hit_ctrl)
      ctrl <= i_pwdata[1:0];
  end

  // Read data and error captured at setup, held through access
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (setup)
    begin
      o_pslverr <= !(hit_ctrl || (hit_status && !i_pwrite));
      if (hit_ctrl)
        o_prdata <= {30'h0000_0000, ctrl};
      else if (hit_status)
        o_prdata <= status;
      else
        o_prdata <= 32'h0000_0000;
    end
  end

  // ************************************************************
  // Assertions and covers
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  chk_reset_hold: assert property (@(posedge i_clk)
    (state == upm_pkg::UPM_RESET) |-> !o_switch_on && !o_osc_en && !o_resync_en)
    else $error("RESET state with switch or oscillator on");
  chk_reset_exit: assert property (
    (state == upm_pkg::UPM_RESET) |=> (state == upm_pkg::UPM_INITIAL) && o_osc_en)
    else $error("RESET did not move to INITIAL");
  chk_init_paths: assert property (
    (state == upm_pkg::UPM_INITIAL) |-> o_switch_on && o_bc_only && !o_resync_en)
    else $error("INITIAL path outputs wrong");
  chk_init_leave: assert property (
    (state == upm_pkg::UPM_INITIAL) |=>
      ((state == upm_pkg::UPM_DISCONNECT) == $past(dwell_done)))
    else $error("INITIAL left at the wrong time");
  chk_disc_enable: assert property (
    (state == upm_pkg::UPM_DISCONNECT) && conn_ok |=>
      (state == upm_pkg::UPM_FULL_LOW) && o_switch_on)
    else $error("DISCONNECT ignored enable");
  chk_fsls_to_hs: assert property (
    (state == upm_pkg::UPM_FULL_LOW) && conn_ok && (i_chirp_end || i_resume_end)
      |=> (state == upm_pkg::UPM_HS))
    else $error("full/low state did not enter HS");
  chk_fsls_drop: assert property (
    (state == upm_pkg::UPM_FULL_LOW) && !conn_ok |=>
      (state == upm_pkg::UPM_DISCONNECT) ##1 o_switch_on)
    else $error("enable low did not disconnect");
  chk_hs_paths: assert property (
    (state == upm_pkg::UPM_HS) && !$past(force_eff) |-> !o_switch_on && o_resync_en)
    else $error("HS path outputs wrong");
  chk_hs_sof: assert property (
    (state == upm_pkg::UPM_HS) && conn_ok && !se0_done && i_sof_rise |=>
      (state == (i_detach_en ? upm_pkg::UPM_DETACH : upm_pkg::UPM_FULL_LOW)))
    else $error("SOF rise took the wrong exit");
  chk_hs_se0: assert property (
    (state == upm_pkg::UPM_HS) && conn_ok && se0_done |=>
      (state == upm_pkg::UPM_FULL_LOW))
    else $error("long SE0 did not return to full/low state");
  chk_detach_leave: assert property (
    (state == upm_pkg::UPM_DETACH) && conn_ok && dwell_done |=>
      (state == upm_pkg::UPM_FULL_LOW) && !o_resync_en)
    else $error("DETACH did not end after its dwell");
  chk_force_path: assert property (
    $past(force_eff) && (state != upm_pkg::UPM_RESET) |-> o_switch_on && !o_resync_en)
    else $error("force did not keep switch on");

  cov_reach_hs:   cover property ($rose(state == upm_pkg::UPM_HS));
  cov_detach:     cover property ((state == upm_pkg::UPM_DETACH) ##1
                                  (state == upm_pkg::UPM_FULL_LOW));
  cov_se0_exit:   cover property ((state == upm_pkg::UPM_HS) && se0_done);
  cov_reattach:   cover property ((state == upm_pkg::UPM_DISCONNECT) ##1
                                  (state == upm_pkg::UPM_FULL_LOW));

endmodule : upm_path_monitor
`default_nettype wire

// [test/upm_line_model.sv]
// Behavioural model of the line conditions seen by the path monitor
`timescale 1ns/1ps
`default_nettype none
module upm_line_model (
  input  wire logic i_clk,
  output logic      o_sof_rise,
  output logic      o_se0,
  output logic      o_chirp_end,
  output logic      o_resume_end
);
  // ************************************************************
  // Idle lines
  // ************************************************************
  initial
  begin
    o_sof_rise   = 1'b0;
    o_se0        = 1'b0;
    o_chirp_end  = 1'b0;
    o_resume_end = 1'b0;
  end

  // One-cycle detection pulse: 0 SOF rise, 1 handshake end, 2 resume end
  task automatic pulse(input int kind);
    @(posedge i_clk);
    case (kind)
      0: o_sof_rise <= 1'b1;
      1: o_chirp_end <= 1'b1;
      default: o_resume_end <= 1'b1;
    endcase
    @(posedge i_clk);
    o_sof_rise   <= 1'b0;
    o_chirp_end  <= 1'b0;
    o_resume_end <= 1'b0;
  endtask : pulse

  // SE0 level held for n sampling edges, then lines go active again
  task automatic se0_run(input int n);
    @(posedge i_clk);
    o_se0 <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_se0 <= 1'b0;
  endtask : se0_run
endmodule : upm_line_model
`default_nettype wire

// [test/upm_path_monitor_bench.sv]
// Self-checking bench for the USB path monitor state machine
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module upm_path_monitor_bench;
  // ************************************************************
  // Short dwell counts keep the run brief
  // ************************************************************
  localparam int unsigned INIT = 20;
  localparam int unsigned DET  = 8;
  localparam int unsigned SE0  = 8;
  logic        clk    = 1'b0;
  logic        rst_b;
  logic        conn;   // Connection enable
  logic        det;    // Detach strap, changed only under reset
  logic        frc;    // Force strap
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] rd;
  logic        err;
  wire logic        sof, se0, chirp, resume, pready, pslverr, sw, bc, rs, osc;
  wire logic [31:0] prdata;
  wire logic [2:0]  st;
  int          n_fail      = 0;
  int          check_count = 0;
  int          n;

  always #4 clk = ~clk;

  upm_path_monitor #(.INIT_CYCLES(INIT), .DETACH_CYCLES(DET), .SE0_CYCLES(SE0))
    upm_path_monitor_inst (.i_clk(clk), .i_rst_b(rst_b), .i_conn_en(conn),
    .i_detach_en(det), .i_force_passthrough(frc), .i_sof_rise(sof), .i_se0(se0),
    .i_chirp_end(chirp), .i_resume_end(resume), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_switch_on(sw), .o_bc_only(bc),
    .o_resync_en(rs), .o_osc_en(osc), .o_state(st));
  upm_line_model upm_line_model_inst (.i_clk(clk), .o_sof_rise(sof), .o_se0(se0),
    .o_chirp_end(chirp), .o_resume_end(resume));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic results;
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // Let k edges pass, then settle past the edge
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  task automatic paths(input logic [2:0] s, input logic w, input logic r);
    `CHK(st, s)
    `CHK(sw, w)
    `CHK(rs, r)
  endtask : paths

  // Samples spent in state s from now on
  task automatic dwell(input logic [2:0] s);
    n = 0;
    while (st === s && n < 5000)
    begin
      n++;
      step(1);
    end
  endtask : dwell

  // APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    #1;
  endtask : apb

  // Reset with straps fixed, then walk INITIAL out
  task automatic do_reset(input logic d, input logic c);
    @(posedge clk);
    rst_b <= 1'b0;
    det   <= d;
    conn  <= c;
    step(8);
    paths(upm_pkg::UPM_RESET, 1'b0, 1'b0);
    `CHK(osc, 1'b0)
    @(posedge clk);
    rst_b <= 1'b1;
    step(1);
    paths(upm_pkg::UPM_INITIAL, 1'b1, 1'b0);
    `CHK(bc, 1'b1)
    `CHK(osc, 1'b1)
    dwell(upm_pkg::UPM_INITIAL);
    `CHK(n, INIT)
    paths(upm_pkg::UPM_DISCONNECT, 1'b1, 1'b0);
    `CHK(bc, 1'b0)
  endtask : do_reset

  // Enable pulsed low for the minimum width, then back high
  task automatic detach_pulse;
    @(posedge clk);
    conn <= 1'b0;
    step(1);
    paths(upm_pkg::UPM_DISCONNECT, 1'b1, 1'b0);
    step(124);
    @(posedge clk);
    conn <= 1'b1;
    step(1);
    paths(upm_pkg::UPM_FULL_LOW, 1'b1, 1'b0);
  endtask : detach_pulse

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_strap_low;
    do_reset(1'b0, 1'b0);
    step(4);
    `CHK(st, upm_pkg::UPM_DISCONNECT)
    @(posedge clk);
    conn <= 1'b1;
    step(1);
    paths(upm_pkg::UPM_FULL_LOW, 1'b1, 1'b0);
    upm_line_model_inst.pulse(1);
    #1;
    paths(upm_pkg::UPM_HS, 1'b0, 1'b1);
    upm_line_model_inst.se0_run(SE0 - 1);
    step(1);
    `CHK(st, upm_pkg::UPM_HS)
    upm_line_model_inst.se0_run(SE0);
    #1;
    paths(upm_pkg::UPM_FULL_LOW, 1'b1, 1'b0);
    upm_line_model_inst.pulse(2);
    #1;
    `CHK(st, upm_pkg::UPM_HS)
    upm_line_model_inst.pulse(0);
    #1;
    paths(upm_pkg::UPM_FULL_LOW, 1'b1, 1'b0);
    upm_line_model_inst.pulse(0);
    #1;
    `CHK(st, upm_pkg::UPM_FULL_LOW)
    detach_pulse();
  endtask : t_strap_low

  task automatic t_strap_high;
    do_reset(1'b1, 1'b1);
    step(1);
    `CHK(st, upm_pkg::UPM_FULL_LOW)
    upm_line_model_inst.pulse(1);
    upm_line_model_inst.pulse(0);
    #1;
    paths(upm_pkg::UPM_DETACH, 1'b0, 1'b0);
    dwell(upm_pkg::UPM_DETACH);
    `CHK(n, DET)
    paths(upm_pkg::UPM_FULL_LOW, 1'b1, 1'b0);
    upm_line_model_inst.pulse(1);
    upm_line_model_inst.se0_run(SE0);
    #1;
    `CHK(st, upm_pkg::UPM_FULL_LOW)
    upm_line_model_inst.pulse(2);
    detach_pulse();
  endtask : t_strap_high

  task automatic t_force;
    @(posedge clk);
    frc <= 1'b1;
    step(2);
    upm_line_model_inst.pulse(1);
    step(1);
    paths(upm_pkg::UPM_HS, 1'b1, 1'b0);
    @(posedge clk);
    frc <= 1'b0;
    step(2);
    paths(upm_pkg::UPM_HS, 1'b0, 1'b1);
    upm_line_model_inst.se0_run(SE0);
    #1;
    paths(upm_pkg::UPM_FULL_LOW, 1'b1, 1'b0);
  endtask : t_force

  task automatic t_regs;
    apb(1'b0, upm_pkg::OFS_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0392)  // Full/low, switch, osc, enable, strap
    apb(1'b1, upm_pkg::OFS_CTRL, 32'h0000_0002);
    `CHK(err, 1'b0)
    step(1);
    `CHK(st, upm_pkg::UPM_DISCONNECT)
    apb(1'b0, upm_pkg::OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0000_0002)
    apb(1'b1, upm_pkg::OFS_STATUS, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h08, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, upm_pkg::OFS_CTRL, 32'h0);
    step(3);
    `CHK(st, upm_pkg::UPM_FULL_LOW)
    // Soft force bit must act like the strap
    apb(1'b1, upm_pkg::OFS_CTRL, 32'h0000_0001);
    upm_line_model_inst.pulse(1);
    #1;
    paths(upm_pkg::UPM_HS, 1'b1, 1'b0);
    apb(1'b1, upm_pkg::OFS_CTRL, 32'h0);
    step(1);
    paths(upm_pkg::UPM_HS, 1'b0, 1'b1);
    `CHK(pready, 1'b1)
  endtask : t_regs

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial
  begin
    rst_b  = 1'b0;
    conn   = 1'b0;
    det    = 1'b0;
    frc    = 1'b0;
    psel   = 1'b0;
    pen    = 1'b0;
    pwr    = 1'b0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    t_strap_low();
    t_strap_high();
    t_force();
    t_regs();
    results();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule : upm_path_monitor_bench
`default_nettype wire
